// *** shared/csf_framer_consts.vh ***
// Constants shared by the character-sync framer, its FIFO and its testbench.
// Assumes it is included by bare name from files under verilog/.
`ifndef CSF_FRAMER_CONSTS_VH
`define CSF_FRAMER_CONSTS_VH

// Sync acquisition styles on syncMode
`define CSF_MODE_MONO    2'h0
`define CSF_MODE_BISYNC  2'h1
`define CSF_MODE_EXT     2'h2

// Bits per character, per sync pattern and per CRC
`define CSF_CHAR_BITS    5'h08
`define CSF_MONO_BITS    5'h08
`define CSF_BI16_BITS    5'h10
`define CSF_BI12_BITS    5'h0C
`define CSF_CRC_BITS     5'h10

// CRC-16 generator and preset
`define CSF_CRC_POLY     16'h8005
`define CSF_CRC_PRESET   16'h0000

// Receive FIFO shape: 8 data bits plus a CRC error flag
`define CSF_FIFO_WIDTH   9
`define CSF_FIFO_DEPTH   8
`define CSF_FIFO_AW      3

// Reset value of the serial line (mark)
`define CSF_LINE_IDLE    1'b1

`endif

// *** verilog/csf_pin_sync.v ***
// Three-stage synchroniser for one pin input of the framer.
// Assumes the pin is asynchronous to clk; output follows once stages 2 and 3 agree.
`timescale 1ns/1ps
module csf_pin_sync (
  input  wire clk,
  input  wire rst_n,
  input  wire clkEn,
  input  wire pinIn,
  output reg  pinOut
);
  reg stage1;  // Metastable stage, read only by stage2
  reg stage2;  // Second stage
  reg stage3;  // Third stage, used for agreement

  // Shift chain; accept a new level only when two settled stages agree
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
      pinOut <= 1'b0;
    end else if (clkEn) begin
      stage1 <= pinIn;
      stage2 <= stage1;
      stage3 <= stage2;
      if (stage2 == stage3) begin
        pinOut <= stage3;
      end
    end
  end
endmodule // csf_pin_sync

// *** verilog/csf_fifo.v ***
// Receive FIFO: parameter width and depth, registered read data.
// Assumes both sides run on clk; valid/ready handshake on each side.
`timescale 1ns/1ps
`include "csf_framer_consts.vh"
module csf_fifo #(
  parameter WIDTH = `CSF_FIFO_WIDTH,
  parameter DEPTH = `CSF_FIFO_DEPTH,
  parameter AW    = `CSF_FIFO_AW
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire             clkEn,
  input  wire             inValid,
  input  wire [WIDTH-1:0] inData,
  output wire             inReady,
  output reg              outValid,
  output reg  [WIDTH-1:0] outData,
  input  wire             outReady
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];  // Storage words
  reg [AW-1:0]    wrPtr;            // Write pointer
  reg [AW-1:0]    rdPtr;            // Read pointer
  reg [AW:0]      count;            // Words held in mem

  wire push = inValid & inReady;                         // Word accepted
  wire load = (count != {(AW+1){1'b0}}) & (~outValid | outReady);  // Refill output

  // Full when mem holds DEPTH words; output register adds one more slot
  assign inReady = (count != DEPTH[AW:0]);

  // Memory write, no reset needed on data
  always @(posedge clk) begin
    if (clkEn && push) begin
      mem[wrPtr] <= inData;
    end
  end

  // Pointers, count and registered output stage
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr    <= {AW{1'b0}};
      rdPtr    <= {AW{1'b0}};
      count    <= {(AW+1){1'b0}};
      outValid <= 1'b0;
      outData  <= {WIDTH{1'b0}};
    end else if (clkEn) begin
      if (push) begin
        wrPtr <= (wrPtr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wrPtr + 1'b1;
      end
      if (load) begin
        outData  <= mem[rdPtr];
        outValid <= 1'b1;
        rdPtr    <= (rdPtr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rdPtr + 1'b1;
      end else if (outReady) begin
        outValid <= 1'b0;
      end
      // Net change of stored words
      case ({push, load})
        2'b10:   count <= count + 1'b1;
        2'b01:   count <= count - 1'b1;
        default: count <= count;
      endcase
    end
  end
endmodule // csf_fifo

// *** verilog/csf_framer.v ***
// Character-oriented synchronous framer for one serial channel: sync hunt,
// character assembly, CRC-16 append and check, and host status/wait logic.
// Assumes bitTick is a one-cycle strobe from a baud generator on clk;
// rxLine and syncPin are asynchronous pins, all other inputs are on clk.
//
// Overview of operation
// RULE1 - Mono mode: send and match one sync char
// RULE2 - After sync, received characters go to FIFO
// RULE3 - Bisync matches 16-bit or 12-bit pattern
// RULE4 - External sync pin marks field start
// RULE5 - Transmitter appends two CRC bytes
// RULE6 - CRC mismatch recorded in receive error FIFO
// RULE7 - Status shows rx available, tx need, errors
// RULE8 - Enabled conditions raise host interrupt
// RULE9 - Wait/request line paces block transfers
// RULE10 - Error flag travels with its data byte
// RULE11 - External mode: assemble from next bit
`timescale 1ns/1ps
`include "csf_framer_consts.vh"
module csf_framer (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        clkEn,
  input  wire        bitTick,
  input  wire [1:0]  syncMode,
  input  wire        sync12,
  input  wire [15:0] syncPattern,
  input  wire        crcEnable,
  input  wire        rxEnable,
  input  wire        rxHunt,
  input  wire        txEnable,
  input  wire        rxLine,
  input  wire        syncPin,
  output reg         txLine,
  input  wire        txValid,
  input  wire [7:0]  txData,
  input  wire        txLast,
  output reg         txReady,
  output wire        rxValid,
  output wire [7:0]  rxData,
  output wire        rxCrcErr,
  input  wire        rxReady,
  input  wire        errClear,
  output reg         statRxAvail,
  output reg         statTxNeed,
  output reg         statErr,
  input  wire        intMaster,
  input  wire        ieRxAvail,
  input  wire        ieTxNeed,
  input  wire        ieErr,
  output reg         irq,
  input  wire        blockMode,
  input  wire        waitOnRx,
  output reg         waitReq
);
  // One-hot receive states
  localparam [1:0] RX_HUNT = 2'b01;
  localparam [1:0] RX_DATA = 2'b10;
  // One-hot transmit states
  localparam [3:0] TX_IDLE = 4'b0001;
  localparam [3:0] TX_SYNC = 4'b0010;
  localparam [3:0] TX_DATA = 4'b0100;
  localparam [3:0] TX_CRC  = 4'b1000;

  // One CRC-16 step, MSB first, used by both directions
  function [15:0] crcStep;
    input [15:0] crc;
    input        bitIn;
    begin
      crcStep = {crc[14:0], 1'b0} ^ ((crc[15] ^ bitIn) ? `CSF_CRC_POLY : 16'h0000);
    end
  endfunction

  wire       rxBit;        // Filtered receive line
  wire       syncLevel;    // Filtered external sync pin
  reg        syncPrev;     // Previous sync level for edge detect
  reg  [1:0] rxState;      // Receive state
  reg [15:0] huntShift;    // Last 16 received bits
  reg  [7:0] rxShift;      // Character being assembled
  reg  [4:0] rxCount;      // Bits of current character
  reg [15:0] rxCrc;        // Running receive CRC
  reg        pushValid;    // Word offered to FIFO
  reg  [8:0] pushWord;     // {crcBad, data}
  reg        overrun;      // Character lost, FIFO full
  wire       pushReady;    // FIFO can take a word
  reg  [3:0] txState;      // Transmit state
  reg [15:0] txShift;      // Outgoing bits, MSB first
  reg  [4:0] txCount;      // Bits left in txShift
  reg [15:0] txCrc;        // Running transmit CRC
  reg  [7:0] holdData;     // Host byte waiting
  reg        holdLast;     // Host byte ends message
  reg        holdFull;     // Holding register occupied
  reg        curLast;      // Byte on the line ends message

  // Pin filters for the two asynchronous inputs
  csf_pin_sync rxSync (
    .clk    (clk),
    .rst_n  (rst_n),
    .clkEn  (clkEn),
    .pinIn  (rxLine),
    .pinOut (rxBit)
  );

  csf_pin_sync extSync (
    .clk    (clk),
    .rst_n  (rst_n),
    .clkEn  (clkEn),
    .pinIn  (syncPin),
    .pinOut (syncLevel)
  );

  // Sync pattern comparison for the chosen mode
  reg syncMatch;
  always @* begin
    syncMatch = 1'b0;
    case (syncMode)
      `CSF_MODE_MONO:   syncMatch = (huntShift[7:0] == syncPattern[7:0]);      // RULE1
      `CSF_MODE_BISYNC: syncMatch = sync12 ?
                          (huntShift[11:0] == syncPattern[11:0]) :
                          (huntShift == syncPattern);                          // RULE3
      default:          syncMatch = 1'b0;                                      // RULE11
    endcase
  end

  // Edge of the filtered external sync level
  wire extStart = syncLevel & ~syncPrev;
  // Next CRC and assembled byte after the current bit
  wire [15:0] next_rxCrc   = crcStep(rxCrc, rxBit);
  wire  [7:0] next_rxShift = {rxShift[6:0], rxBit};

  // Receiver: hunt for sync, then assemble characters
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxState   <= RX_HUNT;
      huntShift <= 16'h0000;
      rxShift   <= 8'h00;
      rxCount   <= 5'h00;
      rxCrc     <= `CSF_CRC_PRESET;
      pushValid <= 1'b0;
      pushWord  <= 9'h000;
      overrun   <= 1'b0;
      syncPrev  <= 1'b0;
    end else if (clkEn) begin
      syncPrev  <= syncLevel;
      pushValid <= 1'b0;
      // Sticky overrun; a new loss wins over a clear
      if (pushValid && !pushReady) begin
        overrun <= 1'b1;
      end else if (errClear) begin
        overrun <= 1'b0;
      end
      if (!rxEnable || rxHunt) begin
        // Disabled or told to re-hunt
        rxState <= RX_HUNT;
        rxCount <= 5'h00;
      end else begin
        case (rxState)
          RX_HUNT: begin
            if (syncMode == `CSF_MODE_EXT) begin
              // Field starts with the bit after the pin edge
              if (extStart) begin
                rxState <= RX_DATA;                                           // RULE4
                rxCount <= 5'h00;                                             // RULE11
                rxCrc   <= `CSF_CRC_PRESET;
              end
            end else if (bitTick) begin
              huntShift <= {huntShift[14:0], rxBit};
            end else if (syncMatch) begin
              // Match on the settled shift register
              rxState   <= RX_DATA;                                           // RULE1
              rxCount   <= 5'h00;
              rxCrc     <= `CSF_CRC_PRESET;
              huntShift <= 16'h0000;
            end
          end
          RX_DATA: begin
            if (bitTick) begin
              rxShift <= next_rxShift;
              rxCrc   <= next_rxCrc;
              if (rxCount == `CSF_CHAR_BITS - 5'h01) begin
                // Whole character: flag travels with it
                rxCount   <= 5'h00;
                pushValid <= 1'b1;                                            // RULE2
                pushWord  <= {crcEnable & (next_rxCrc != 16'h0000),
                              next_rxShift};                                  // RULE6 RULE10
              end else begin
                rxCount <= rxCount + 5'h01;
              end
            end
          end
          default: rxState <= RX_HUNT;
        endcase
      end
    end
  end

  // Receive FIFO; a full FIFO drops the byte and flags overrun
  csf_fifo #(
    .WIDTH (`CSF_FIFO_WIDTH),
    .DEPTH (`CSF_FIFO_DEPTH),
    .AW    (`CSF_FIFO_AW)
  ) rxFifo (
    .clk      (clk),
    .rst_n    (rst_n),
    .clkEn    (clkEn),
    .inValid  (pushValid),
    .inData   (pushWord),
    .inReady  (pushReady),
    .outValid (rxValid),
    .outData  ({rxCrcErr, rxData}),
    .outReady (rxReady)
  );

  // Transmitter: sync, data, CRC, then idle
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      txState  <= TX_IDLE;
      txShift  <= 16'h0000;
      txCount  <= 5'h00;
      txCrc    <= `CSF_CRC_PRESET;
      txLine   <= `CSF_LINE_IDLE;
      holdData <= 8'h00;
      holdLast <= 1'b0;
      holdFull <= 1'b0;
      txReady  <= 1'b0;
      curLast  <= 1'b0;
    end else if (clkEn) begin
      // Host side of the holding register
      if (txValid && txReady) begin
        holdData <= txData;
        holdLast <= txLast;
        holdFull <= 1'b1;
        txReady  <= 1'b0;
      end else if (!holdFull) begin
        txReady <= txEnable;
      end
      if (bitTick) begin
        // Shift one bit onto the line
        if (txCount != 5'h00) begin
          txLine  <= txShift[15];
          txShift <= {txShift[14:0], 1'b0};
          txCount <= txCount - 5'h01;
          if (txState == TX_DATA) begin
            txCrc <= crcStep(txCrc, txShift[15]);                             // RULE5
          end
        end else begin
          txLine <= `CSF_LINE_IDLE;
        end
        // Choose the next unit when the shifter empties
        if (txCount <= 5'h01) begin
          case (txState)
            TX_IDLE: begin
              if (txEnable && holdFull) begin
                if (syncMode == `CSF_MODE_EXT) begin
                  // No sync character; far end marks the field by pin
                  txState  <= TX_DATA;
                  txShift  <= {holdData, 8'h00};
                  txCount  <= `CSF_CHAR_BITS;
                  curLast  <= holdLast;
                  holdFull <= 1'b0;
                  txCrc    <= `CSF_CRC_PRESET;
                end else begin
                  txState <= TX_SYNC;
                  txCrc   <= `CSF_CRC_PRESET;
                  if (syncMode == `CSF_MODE_MONO) begin
                    txShift <= {syncPattern[7:0], 8'h00};                     // RULE1
                    txCount <= `CSF_MONO_BITS;
                  end else if (sync12) begin
                    txShift <= {syncPattern[11:0], 4'h0};                     // RULE3
                    txCount <= `CSF_BI12_BITS;
                  end else begin
                    txShift <= syncPattern;
                    txCount <= `CSF_BI16_BITS;
                  end
                end
              end
            end
            TX_SYNC, TX_DATA: begin
              if (txState == TX_DATA && curLast) begin
                // Message done: append CRC or stop
                if (crcEnable) begin
                  txState <= TX_CRC;
                  txShift <= crcStep(txCrc, txShift[15]);                     // RULE5
                  txCount <= `CSF_CRC_BITS;
                end else begin
                  txState <= TX_IDLE;
                end
              end else if (holdFull) begin
                txState  <= TX_DATA;
                txShift  <= {holdData, 8'h00};
                txCount  <= `CSF_CHAR_BITS;
                curLast  <= holdLast;
                holdFull <= 1'b0;
              end else begin
                // Underrun: go back to idle and mark the line until the next byte
                txState <= TX_IDLE;
              end
            end
            TX_CRC: begin
              txState <= TX_IDLE;
            end
            default: txState <= TX_IDLE;
          endcase
        end
      end
    end
  end

  // Host status, interrupt and wait/request, all registered
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      statRxAvail <= 1'b0;
      statTxNeed  <= 1'b0;
      statErr     <= 1'b0;
      irq         <= 1'b0;
      waitReq     <= 1'b0;
    end else if (clkEn) begin
      statRxAvail <= rxValid;                                                 // RULE7
      statTxNeed  <= txEnable & ~holdFull;                                    // RULE7
      statErr     <= overrun | (rxValid & rxCrcErr);                          // RULE7
      irq         <= intMaster & ((ieRxAvail & rxValid) |
                                  (ieTxNeed & txEnable & ~holdFull) |
                                  (ieErr & (overrun | (rxValid & rxCrcErr))));  // RULE8
      // Hold off the host until the channel can take or give a byte
      waitReq     <= blockMode & (waitOnRx ? ~rxValid : holdFull);            // RULE9
    end
  end
endmodule // csf_framer

// *** tb/csf_framer_checker.sv ***
// Port-level timing checks for the character-sync framer.
// Assumes one clock domain and the async active-low reset of the framer.
`timescale 1ns/1ps
module csf_framer_checker (
  input wire       clk,
  input wire       rst_n,
  input wire       clkEn,
  input wire       bitTick,
  input wire       txEnable,
  input wire       txLine,
  input wire       txValid,
  input wire       txReady,
  input wire       rxValid,
  input wire [7:0] rxData,
  input wire       rxCrcErr,
  input wire       rxReady,
  input wire       statRxAvail,
  input wire       intMaster,
  input wire       ieRxAvail,
  input wire       irq,
  input wire       blockMode,
  input wire       waitOnRx,
  input wire       waitReq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_ready_drop:
    assert property (clkEn && txValid && txReady |=> !txReady) else $error("txReady held after a take");
  a_line_tick:
    assert property ($changed(txLine) && $past(txEnable) |-> $past(bitTick)) else $error("txLine moved off a bit");
  a_head_hold:
    assert property (rxValid && !rxReady |=> rxValid && $stable(rxData) && $stable(rxCrcErr))
      else $error("rx head changed before pop");
  a_push_tick:
    assert property ($rose(rxValid) |-> $past(bitTick) || $past(bitTick, 2) || $past(bitTick, 3)
      || $past(bitTick, 4) || $past(bitTick, 5)) else $error("rx byte without a bit");
  a_stat_avail:
    assert property (clkEn |=> statRxAvail == $past(rxValid)) else $error("rx status lags wrongly");
  a_irq_quiet:
    assert property (!intMaster ##1 !intMaster |-> !irq) else $error("irq while masked");
  a_irq_rx:
    assert property (intMaster && ieRxAvail && statRxAvail [*2] |-> irq) else $error("no irq for rx");
  a_wait_empty:
    assert property (blockMode && waitOnRx && !rxValid [*2] |-> waitReq) else $error("no wait on empty rx");
endmodule // csf_framer_checker

bind csf_framer csf_framer_checker i_chk (
  .clk(clk), .rst_n(rst_n), .clkEn(clkEn), .bitTick(bitTick), .txEnable(txEnable), .txLine(txLine),
  .txValid(txValid), .txReady(txReady), .rxValid(rxValid), .rxData(rxData), .rxCrcErr(rxCrcErr),
  .rxReady(rxReady), .statRxAvail(statRxAvail), .intMaster(intMaster), .ieRxAvail(ieRxAvail),
  .irq(irq), .blockMode(blockMode), .waitOnRx(waitOnRx), .waitReq(waitReq));

// *** tb/csf_remote_station.sv ***
// Remote serial station: sends framed bits and records the framer's line.
// Assumes bitTick paces both directions; the line idles at mark.
`timescale 1ns/1ps
module csf_remote_station (
  input wire clk,
  input wire bitTick,
  input wire txLine,
  output reg rxLine,
  output reg syncPin
);
  reg [127:0] heard; // Bits heard, newest at bit 0

  initial begin
    rxLine = 1'b1;
    syncPin = 1'b0;
    heard = 128'h0;
  end

  // One sample per bit of the framer's line
  always @(posedge clk) begin
    if (bitTick) begin
      heard <= {heard[126:0], txLine};
    end
  end

  // Send len bits, MSB first, each held a full bit
  task send(input [63:0] bits, input integer len, input ext);
    integer i;
    begin
      for (i = 0; i < len; i = i + 1) begin
        @(posedge clk iff bitTick);
        @(negedge clk);
        rxLine = bits[63-i];
        if (ext && i == 0) syncPin = 1'b1;
        if (i == 2) syncPin = 1'b0;
      end
      @(posedge clk iff bitTick);
      @(negedge clk);
      rxLine = 1'b1; // Back to mark once the last bit is taken
    end
  endtask
endmodule // csf_remote_station

// *** tb/testbench.sv ***
// Self-checking bench for csf_framer with a remote station model.
// Assumes the framer header is on the include path.
`timescale 1ns/1ps
`include "csf_framer_consts.vh"
module testbench;
  typedef struct packed {
    logic [1:0] mode; logic s12; logic [15:0] pat; logic crc; logic [2:0] n; logic [31:0] data; logic bad;
  } row_t;
  reg        clk, rst_n, clkEn, bitTick, sync12, crcEnable, rxEnable, rxHunt, txEnable;
  reg        txValid, txLast, rxReady, errClear, intMaster, ieRxAvail, ieTxNeed, ieErr;
  reg        blockMode, waitOnRx, hit;
  reg [1:0]  syncMode;
  reg [15:0] syncPattern;
  reg [7:0]  txData;
  reg [2:0]  tickCnt;
  reg [63:0] fv;      // Frame bits, left aligned
  reg [8:0]  w;       // Popped word
  wire       rxLine, syncPin, txLine, txReady, rxValid, rxCrcErr, statRxAvail, statTxNeed, statErr, irq, waitReq;
  wire [7:0] rxData;
  integer    flen, err_total, checked, i, k;
  row_t      rows [0:4];

  csf_framer i_dut (
    .clk(clk), .rst_n(rst_n), .clkEn(clkEn), .bitTick(bitTick), .syncMode(syncMode), .sync12(sync12),
    .syncPattern(syncPattern), .crcEnable(crcEnable), .rxEnable(rxEnable), .rxHunt(rxHunt),
    .txEnable(txEnable), .rxLine(rxLine), .syncPin(syncPin), .txLine(txLine), .txValid(txValid),
    .txData(txData), .txLast(txLast), .txReady(txReady), .rxValid(rxValid), .rxData(rxData),
    .rxCrcErr(rxCrcErr), .rxReady(rxReady), .errClear(errClear), .statRxAvail(statRxAvail),
    .statTxNeed(statTxNeed), .statErr(statErr), .intMaster(intMaster), .ieRxAvail(ieRxAvail),
    .ieTxNeed(ieTxNeed), .ieErr(ieErr), .irq(irq), .blockMode(blockMode), .waitOnRx(waitOnRx),
    .waitReq(waitReq));
  csf_remote_station i_remote (
    .clk(clk), .bitTick(bitTick), .txLine(txLine), .rxLine(rxLine), .syncPin(syncPin));

  // 100 MHz clock
  always #5 clk = ~clk;

  // Bit strobe every 8 cycles, leaves idle cycles between bits
  always @(negedge clk) begin
    tickCnt <= tickCnt + 3'h1;
    bitTick <= (tickCnt == 3'h7);
  end

  // CRC-16 over one byte, MSB first
  function automatic [15:0] crc_step(input [15:0] c, input [7:0] b);
    integer j;
    begin
      for (j = 7; j >= 0; j = j - 1)
        c = {c[14:0], 1'b0} ^ ((c[15] ^ b[j]) ? `CSF_CRC_POLY : 16'h0000);
      crc_step = c;
    end
  endfunction

  task chk(input [7:0] seen, input [7:0] want, input [8*12-1:0] what);
    begin
      checked = checked + 1;
      if (seen !== want) begin
        err_total = err_total + 1;
        $display("BAD t=%0t %0s seen %h want %h", $time, what, seen, want);
      end
    end
  endtask

  task app(input [15:0] v, input integer n);
    begin
      fv = fv | ({v, 48'h0} >> flen);
      flen = flen + n;
    end
  endtask

  // Sync, data, then CRC (flip spoils it)
  task build(input row_t r, input withSync, input flip);
    reg [15:0] c;
    reg [7:0]  b;
    integer    m;
    begin
      fv = 64'h0;
      flen = 0;
      c = `CSF_CRC_PRESET;
      if (withSync && r.mode == `CSF_MODE_MONO) app({r.pat[7:0], 8'h00}, 8);
      if (withSync && r.mode == `CSF_MODE_BISYNC) app(r.s12 ? {r.pat[11:0], 4'h0} : r.pat, r.s12 ? 12 : 16);
      for (m = 0; m < r.n; m = m + 1) begin
        b = r.data[31-8*m -: 8];
        c = crc_step(c, b);
        app({b, 8'h00}, 8);
      end
      if (r.crc) app(c ^ {15'h0, flip}, 16);
    end
  endtask

  task pulse_hunt;
    begin
      rxHunt = 1'b1;
      @(negedge clk);
      rxHunt = 1'b0;
    end
  endtask

  // Wait for a head word, then pop it
  task pop;
    integer m;
    begin
      for (m = 0; m < 2000 && rxValid !== 1'b1; m = m + 1) @(negedge clk);
      w = {rxCrcErr, rxData};
      rxReady = 1'b1;
      @(negedge clk);
      rxReady = 1'b0;
      @(negedge clk);
    end
  endtask

  // Offer a byte until taken
  task put_tx(input [7:0] b, input last);
    integer m;
    begin
      txValid = 1'b1;
      txData = b;
      txLast = last;
      for (m = 0; m < 2000 && txReady !== 1'b1; m = m + 1) @(negedge clk);
      @(negedge clk);
    end
  endtask

  task run_row(input row_t r);
    begin
      syncMode = r.mode;
      sync12 = r.s12;
      syncPattern = r.pat;
      crcEnable = r.crc;
      pulse_hunt;
      build(r, 1'b1, r.bad);
      i_remote.send(fv, flen, r.mode == `CSF_MODE_EXT);
      repeat (16) @(negedge clk);
      pulse_hunt; // Stop before idle marks fill the FIFO
      build(r, 1'b0, r.bad);
      for (k = 0; k < r.n + (r.crc ? 2 : 0); k = k + 1) begin
        pop;
        chk(w[7:0], fv[63-8*k -: 8], "rx byte");
      end
      if (r.crc) chk({7'h00, w[8]}, {7'h00, r.bad}, "crc flag");
      chk({7'h00, rxValid}, 8'h00, "rx empty");
      // Transmit the same message; external mode sends no pattern
      txEnable = 1'b1;
      repeat (4) @(negedge clk);
      chk({7'h00, statTxNeed}, 8'h01, "tx need");
      for (k = 0; k < r.n; k = k + 1) put_tx(r.data[31-8*k -: 8], k == r.n - 1);
      txValid = 1'b0;
      repeat (400) @(negedge clk);
      build(r, 1'b1, 1'b0);
      hit = 1'b0;
      for (k = 0; k <= 128 - flen; k = k + 1)
        if (((i_remote.heard >> k) & ((128'h1 << flen) - 128'h1)) == (fv >> (64 - flen))) hit = 1'b1;
      chk({7'h00, hit}, 8'h01, "tx frame");
      txEnable = 1'b0;
    end
  endtask

  task close_out;
    begin
      $display("checked %0d err_total %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask

  // Watchdog, well beyond the expected run
  initial begin
    #1000000;
    err_total = err_total + 1;
    close_out;
  end

  initial begin
    {clk, rst_n, bitTick, sync12, crcEnable, rxHunt, txEnable, txValid, txLast, rxReady} = 10'h0;
    {errClear, intMaster, ieRxAvail, ieTxNeed, ieErr, blockMode, waitOnRx} = 7'h0;
    {clkEn, rxEnable} = 2'h3;
    syncMode = `CSF_MODE_MONO;
    syncPattern = 16'h0000;
    txData = 8'h00;
    tickCnt = 3'h0;
    err_total = 0;
    checked = 0;
    rows[0] = '{`CSF_MODE_MONO, 1'b0, 16'h0016, 1'b1, 3'h3, 32'hA1B2C300, 1'b0};
    rows[1] = '{`CSF_MODE_BISYNC, 1'b0, 16'h1F35, 1'b1, 3'h4, 32'h0F5AC3E7, 1'b0};
    rows[2] = '{`CSF_MODE_BISYNC, 1'b1, 16'h05A3, 1'b1, 3'h2, 32'h3C690000, 1'b1};
    rows[3] = '{`CSF_MODE_EXT, 1'b0, 16'h0016, 1'b1, 3'h2, 32'h96E10000, 1'b0};
    rows[4] = '{`CSF_MODE_MONO, 1'b0, 16'h0032, 1'b0, 3'h1, 32'h5D000000, 1'b0};
    repeat (3) @(negedge clk);
    chk({txLine, rxValid, irq, waitReq, statErr}, 8'h10, "reset outs");
    @(negedge clk);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    ieRxAvail = 1'b1;
    for (i = 0; i < 5; i = i + 1) begin
      intMaster = (i >= 2);
      run_row(rows[i]);
    end
    // Overrun: idle marks keep arriving after seven bytes
    syncMode = `CSF_MODE_MONO;
    syncPattern = 16'h0016;
    crcEnable = 1'b0;
    {blockMode, waitOnRx, ieErr, ieRxAvail} = 4'hE;
    pulse_hunt;
    i_remote.send({8'h16, 56'h11223344556677}, 64, 1'b0);
    repeat (300) @(negedge clk);
    pulse_hunt;
    chk({7'h00, statErr}, 8'h01, "overrun");
    chk({7'h00, irq}, 8'h01, "err irq");
    // Seven data bytes, then two idle-mark bytes fill the FIFO and its head
    for (i = 0; i < 9; i = i + 1) begin
      pop;
      chk(w[7:0], (i < 7) ? 8'h11 * (i[7:0] + 8'h01) : 8'hFF, "fifo word");
    end
    errClear = 1'b1;
    @(negedge clk);
    errClear = 1'b0;
    repeat (3) @(negedge clk);
    chk({7'h00, statErr}, 8'h00, "err clear");
    chk({7'h00, waitReq}, 8'h01, "rx wait");
    // Transmit side: interrupt on need, wait while the held byte sits
    {waitOnRx, ieErr, ieTxNeed, txEnable} = 4'h3;
    repeat (3) @(negedge clk);
    chk({7'h00, irq}, 8'h01, "tx irq");
    put_tx(8'hC4, 1'b1);
    txValid = 1'b0;
    repeat (2) @(negedge clk);
    chk({7'h00, waitReq}, 8'h01, "tx wait");
    {blockMode, intMaster} = 2'h0;
    repeat (4) @(negedge clk);
    chk({7'h00, irq}, 8'h00, "irq masked");
    close_out;
  end
endmodule // testbench
